/* logic/dmt_pkg.sv */
// constants and register map of the dual mode compare timer
// Functional notes
// - count word is two cascaded bytes
// - reset clears both counter bytes
// - reset sets compare bytes to ones
// - 16-bit mode uses low clock select
// - word wrap sets high overflow flag
// - overflow with enable raises high request
// - 8-bit bytes wrap and flag independently
// - 16-bit match clears word if enabled
// - 8-bit match clears own byte if enabled
// - 16-bit compare sets high match, request
// - 8-bit compares set own match, request
// - match toggles associated output pin
// - control bit 7 sets high pin
// - control bit 3 sets low pin
// - decode high clock select field
// - decode low clock select field
// - event edge chosen by edge select
// - control register write only, resets zero
// - status resets zero, flags clear only
// - high overflow cleared by read-then-zero
// - 16-bit mode uses byte staging latch
// - upper byte write staged, lower commits
// - upper read captures lower into latch
// - compare reads bypass staging latch
// - match flags cleared by read-then-zero
package dmt_pkg;
    localparam logic [2:0] DMT_ADDR_CTRL = 3'h0;
    localparam logic [2:0] DMT_ADDR_STAT = 3'h1;
    localparam logic [2:0] DMT_ADDR_CNTH = 3'h2;
    localparam logic [2:0] DMT_ADDR_CNTL = 3'h3;
    localparam logic [2:0] DMT_ADDR_CMPH = 3'h4;
    localparam logic [2:0] DMT_ADDR_CMPL = 3'h5;
    localparam logic [7:0] DMT_CNT_RST = 8'h00;
    localparam logic [7:0] DMT_CMP_RST = 8'hFF;
    localparam logic [7:0] DMT_REG_RST = 8'h00;
    localparam logic [7:0] DMT_BYTE_MAX = 8'hFF;
    localparam int DMT_CTL_HLVL = 7;
    localparam int DMT_CTL_HMODE = 6;
    localparam int DMT_CTL_LLVL = 3;
    localparam int DMT_CTL_LSRC = 2;
    localparam int DMT_ST_HIGH_OVERFLOW_FLAG = 7;
    localparam int DMT_ST_HIGH_MATCH_FLAG = 6;
    localparam int DMT_ST_HIGH_OVERFLOW_IRQ_ENABLE = 5;
    localparam int DMT_ST_HIGH_CLEAR_ON_MATCH = 4;
    localparam int DMT_ST_LOW_OVERFLOW_FLAG = 3;
    localparam int DMT_ST_LOW_MATCH_FLAG = 2;
    localparam int DMT_ST_LOW_OVERFLOW_IRQ_ENABLE = 1;
    localparam int DMT_ST_LOW_CLEAR_ON_MATCH = 0;
    localparam int DMT_PRESC_W = 5;
    localparam logic [1:0] DMT_SEL_D32 = 2'h0;
    localparam logic [1:0] DMT_SEL_D16 = 2'h1;
    localparam logic [1:0] DMT_SEL_D4 = 2'h2;
    localparam logic [1:0] DMT_SEL_D2 = 2'h3;
    typedef enum logic [1:0] {
        DMT_SRC_EXT = 2'b00,
        DMT_SRC_INT = 2'b01,
        DMT_SRC_CAS = 2'b10
    } dmt_src_t;
endpackage : dmt_pkg

/* logic/dmt_tick.sv */
// tick generator: picks a prescaler tap or an external edge for one counter byte
`timescale 1ns/1ps
module dmt_tick
    import dmt_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [DMT_PRESC_W-1:0] presc_i,
    input wire logic [1:0] tap_sel_i,
    input wire logic use_ext_i,
    input wire logic ext_pin_i,
    input wire logic rising_i,
    output logic tick_o
);
    logic ext_q;
    logic tap_q;
    logic tap_now;
    // the pin may idle high, so the first sample after reset must not read as an edge
    logic prime_q;

    always_comb begin
        case (tap_sel_i)
            DMT_SEL_D32: tap_now = presc_i[4];
            DMT_SEL_D16: tap_now = presc_i[3];
            DMT_SEL_D4: tap_now = presc_i[1];
            DMT_SEL_D2: tap_now = presc_i[0];
            default: tap_now = presc_i[0];
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_q <= 1'b0;
            tap_q <= 1'b0;
            prime_q <= 1'b0;
        end else begin
            ext_q <= ext_pin_i;
            tap_q <= tap_now;
            prime_q <= 1'b1;
        end
    end

    // one tick per falling tap edge gives exactly phi/2^n; external edge polarity selectable
    always_comb begin
        if (use_ext_i) begin
            tick_o = prime_q & (rising_i ? (ext_pin_i & ~ext_q) : (~ext_pin_i & ext_q));
        end else begin
            tick_o = tap_q & ~tap_now;
        end
    end
endmodule : dmt_tick

/* logic/dmt_timer.sv */
// dual mode compare timer top: counters, compare, flags, toggle pins, byte bus
`timescale 1ns/1ps
module dmt_timer
    import dmt_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [2:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic [DMT_PRESC_W-1:0] presc_i,
    input wire logic event_input_pin_i,
    input wire logic event_edge_select_i,
    output logic [7:0] bus_rdata_o,
    output logic high_irq_request_o,
    output logic low_irq_request_o,
    output logic high_toggle_pin_o,
    output logic low_toggle_pin_o
);
    logic [7:0] ctrl_q;
    logic [7:0] stat_q;
    logic [7:0] cnt_h_q;
    logic [7:0] cnt_l_q;
    logic [7:0] cmp_h_q;
    logic [7:0] cmp_l_q;
    logic [7:0] stage_q;
    logic [3:0] seen_q;
    logic tick_l;
    logic tick_h_int;
    logic mode8;
    logic tick_h;
    logic wrap_l;
    logic wrap_h;
    logic match_w;
    logic match_h;
    logic match_l;
    logic clr_h;
    logic clr_l;
    logic ev_high_overflow_flag;
    logic ev_high_match_flag;
    logic ev_low_overflow_flag;
    logic ev_low_match_flag;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_cnth;
    logic wr_cntl;
    logic wr_cmph;
    logic wr_cmpl;
    dmt_src_t src_h;

    function automatic logic flag_next(input logic cur, input logic ev, input logic wr, input logic bit_w,
                                       input logic seen);
        // set wins over a clear in the same cycle
        flag_next = ev | (cur & ~(wr & ~bit_w & seen));
    endfunction : flag_next

    assign mode8 = ctrl_q[DMT_CTL_HMODE];
    assign src_h = mode8 ? DMT_SRC_INT : DMT_SRC_CAS;

    assign wr_ctrl = bus_wr_i && bus_addr_i == DMT_ADDR_CTRL;
    assign wr_stat = bus_wr_i && bus_addr_i == DMT_ADDR_STAT;
    assign wr_cnth = bus_wr_i && bus_addr_i == DMT_ADDR_CNTH;
    assign wr_cntl = bus_wr_i && bus_addr_i == DMT_ADDR_CNTL;
    assign wr_cmph = bus_wr_i && bus_addr_i == DMT_ADDR_CMPH;
    assign wr_cmpl = bus_wr_i && bus_addr_i == DMT_ADDR_CMPL;

    dmt_tick u_tick_l (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .presc_i(presc_i),
        .tap_sel_i(ctrl_q[1:0]),
        .use_ext_i(~ctrl_q[DMT_CTL_LSRC]),
        .ext_pin_i(event_input_pin_i),
        .rising_i(event_edge_select_i),
        .tick_o(tick_l)
    );

    dmt_tick u_tick_h (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .presc_i(presc_i),
        .tap_sel_i(ctrl_q[5:4]),
        .use_ext_i(1'b0),
        .ext_pin_i(1'b0),
        .rising_i(1'b0),
        .tick_o(tick_h_int)
    );

    // in 16-bit mode the high byte steps on low byte carry, driven by the low clock select
    always_comb begin
        case (src_h)
            DMT_SRC_INT: tick_h = tick_h_int;
            DMT_SRC_CAS: tick_h = wrap_l;
            default: tick_h = 1'b0;
        endcase
    end

    assign match_w = {cnt_h_q, cnt_l_q} == {cmp_h_q, cmp_l_q};
    assign match_h = mode8 ? (cnt_h_q == cmp_h_q) : match_w;
    assign match_l = mode8 && cnt_l_q == cmp_l_q;
    assign clr_l = mode8 ? (match_l & stat_q[DMT_ST_LOW_CLEAR_ON_MATCH]) : (match_w & stat_q[DMT_ST_HIGH_CLEAR_ON_MATCH]);
    assign clr_h = match_h & stat_q[DMT_ST_HIGH_CLEAR_ON_MATCH];
    assign wrap_l = tick_l && !clr_l && cnt_l_q == DMT_BYTE_MAX;
    assign wrap_h = tick_h && !clr_h && cnt_h_q == DMT_BYTE_MAX;

    // compare is level; only the first cycle of equality counts as a match event
    logic match_h_q;
    logic match_l_q;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            match_h_q <= 1'b0;
            match_l_q <= 1'b0;
        end else begin
            match_h_q <= match_h;
            match_l_q <= match_l;
        end
    end
    assign ev_high_match_flag = match_h & ~match_h_q;
    assign ev_low_match_flag = match_l & ~match_l_q;
    assign ev_high_overflow_flag = wrap_h;
    assign ev_low_overflow_flag = mode8 & wrap_l;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= DMT_REG_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= bus_wdata_i;
        end
    end

    // low counter byte: bus write commits in 16-bit mode together with staged high byte
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_l_q <= DMT_CNT_RST;
        end else if (wr_cntl) begin
            cnt_l_q <= bus_wdata_i;
        end else if (clr_l && (match_l || match_w)) begin
            cnt_l_q <= DMT_CNT_RST;
        end else if (tick_l) begin
            cnt_l_q <= cnt_l_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_h_q <= DMT_CNT_RST;
        end else if (wr_cntl && !mode8) begin
            cnt_h_q <= stage_q;
        end else if (wr_cnth && mode8) begin
            cnt_h_q <= bus_wdata_i;
        end else if (clr_h) begin
            cnt_h_q <= DMT_CNT_RST;
        end else if (tick_h) begin
            cnt_h_q <= cnt_h_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_h_q <= DMT_CMP_RST;
            cmp_l_q <= DMT_CMP_RST;
        end else begin
            if (wr_cmpl) begin
                cmp_l_q <= bus_wdata_i;
                if (!mode8) begin
                    cmp_h_q <= stage_q;
                end
            end
            if (wr_cmph && mode8) begin
                cmp_h_q <= bus_wdata_i;
            end
        end
    end

    // staging latch: upper-byte writes park here; upper counter read captures the low byte
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage_q <= DMT_REG_RST;
        end else if (!mode8) begin
            if (wr_cnth || wr_cmph) begin
                stage_q <= bus_wdata_i;
            end else if (bus_rd_i && bus_addr_i == DMT_ADDR_CNTH) begin
                stage_q <= cnt_l_q;
            end
        end
    end

    // a flag may be cleared only after software has read it as one
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            seen_q <= 4'h0;
        end else if (bus_rd_i && bus_addr_i == DMT_ADDR_STAT) begin
            seen_q <= {stat_q[DMT_ST_HIGH_OVERFLOW_FLAG], stat_q[DMT_ST_HIGH_MATCH_FLAG], stat_q[DMT_ST_LOW_OVERFLOW_FLAG], stat_q[DMT_ST_LOW_MATCH_FLAG]};
        end else if (wr_stat) begin
            seen_q <= 4'h0;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stat_q <= DMT_REG_RST;
        end else begin
            stat_q[DMT_ST_HIGH_OVERFLOW_FLAG] <= flag_next(stat_q[DMT_ST_HIGH_OVERFLOW_FLAG], ev_high_overflow_flag, wr_stat,
                                             bus_wdata_i[DMT_ST_HIGH_OVERFLOW_FLAG], seen_q[3]);
            stat_q[DMT_ST_HIGH_MATCH_FLAG] <= flag_next(stat_q[DMT_ST_HIGH_MATCH_FLAG], ev_high_match_flag, wr_stat,
                                             bus_wdata_i[DMT_ST_HIGH_MATCH_FLAG], seen_q[2]);
            stat_q[DMT_ST_LOW_OVERFLOW_FLAG] <= flag_next(stat_q[DMT_ST_LOW_OVERFLOW_FLAG], ev_low_overflow_flag, wr_stat,
                                             bus_wdata_i[DMT_ST_LOW_OVERFLOW_FLAG], seen_q[1]);
            stat_q[DMT_ST_LOW_MATCH_FLAG] <= flag_next(stat_q[DMT_ST_LOW_MATCH_FLAG], ev_low_match_flag, wr_stat,
                                             bus_wdata_i[DMT_ST_LOW_MATCH_FLAG], seen_q[0]);
            if (wr_stat) begin
                stat_q[DMT_ST_HIGH_OVERFLOW_IRQ_ENABLE] <= bus_wdata_i[DMT_ST_HIGH_OVERFLOW_IRQ_ENABLE];
                stat_q[DMT_ST_HIGH_CLEAR_ON_MATCH] <= bus_wdata_i[DMT_ST_HIGH_CLEAR_ON_MATCH];
                stat_q[DMT_ST_LOW_OVERFLOW_IRQ_ENABLE] <= bus_wdata_i[DMT_ST_LOW_OVERFLOW_IRQ_ENABLE];
                stat_q[DMT_ST_LOW_CLEAR_ON_MATCH] <= bus_wdata_i[DMT_ST_LOW_CLEAR_ON_MATCH];
            end
        end
    end

    // request lines are one-cycle pulses into the external request register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_irq_request_o <= 1'b0;
            low_irq_request_o <= 1'b0;
        end else begin
            high_irq_request_o <= ev_high_match_flag | (ev_high_overflow_flag & stat_q[DMT_ST_HIGH_OVERFLOW_IRQ_ENABLE]);
            low_irq_request_o <= ev_low_match_flag | (ev_low_overflow_flag & stat_q[DMT_ST_LOW_OVERFLOW_IRQ_ENABLE]);
        end
    end

    // pin writes win over a toggle in the same cycle, so software level is deterministic
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_toggle_pin_o <= 1'b0;
            low_toggle_pin_o <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                high_toggle_pin_o <= bus_wdata_i[DMT_CTL_HLVL];
                low_toggle_pin_o <= bus_wdata_i[DMT_CTL_LLVL];
            end else begin
                if (ev_high_match_flag) begin
                    high_toggle_pin_o <= ~high_toggle_pin_o;
                end
                if (ev_low_match_flag) begin
                    low_toggle_pin_o <= ~low_toggle_pin_o;
                end
            end
        end
    end

    // registered read data; control register reads back zero
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_rdata_o <= DMT_REG_RST;
        end else if (bus_rd_i) begin
            case (bus_addr_i)
                DMT_ADDR_STAT: bus_rdata_o <= stat_q;
                DMT_ADDR_CNTH: bus_rdata_o <= cnt_h_q;
                DMT_ADDR_CNTL: bus_rdata_o <= mode8 ? cnt_l_q : stage_q;
                DMT_ADDR_CMPH: bus_rdata_o <= cmp_h_q;
                DMT_ADDR_CMPL: bus_rdata_o <= cmp_l_q;
                default: bus_rdata_o <= DMT_REG_RST;
            endcase
        end
    end
endmodule : dmt_timer

/* dv/dmt_timer_asserts.sv */
// port-level checker of the dual mode compare timer
`timescale 1ns/1ps
module dmt_timer_asserts
    import dmt_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [2:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic [DMT_PRESC_W-1:0] presc_i,
    input wire logic event_input_pin_i,
    input wire logic event_edge_select_i,
    input wire logic [7:0] bus_rdata_o,
    input wire logic high_irq_request_o,
    input wire logic low_irq_request_o,
    input wire logic high_toggle_pin_o,
    input wire logic low_toggle_pin_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [7:0] ctrl_q;
    logic [2:0] quiet_q;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) ctrl_q <= 8'h00;
        else if (bus_wr_i && bus_addr_i == DMT_ADDR_CTRL) ctrl_q <= bus_wdata_i;
    end
    // any bus write may create a match, so it restarts the quiet span too
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) quiet_q <= 3'h0;
        else if (bus_wr_i || $changed(event_input_pin_i)) quiet_q <= 3'h0;
        else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
    end
    sequence s_ctrl_wr;
        bus_wr_i && bus_addr_i == DMT_ADDR_CTRL;
    endsequence
    sequence s_ctrl_rd;
        bus_rd_i && bus_addr_i == DMT_ADDR_CTRL;
    endsequence
    a_high_level_set: assert property (s_ctrl_wr |=> high_toggle_pin_o == $past(bus_wdata_i[7]))
        else $error("high pin level not taken from control write");
    a_low_level_set: assert property (s_ctrl_wr |=> low_toggle_pin_o == $past(bus_wdata_i[3]))
        else $error("low pin level not taken from control write");
    a_ctrl_read_zero: assert property (s_ctrl_rd |=> bus_rdata_o == 8'h00)
        else $error("control register readable");
    a_unmapped_read: assert property (bus_rd_i && bus_addr_i > DMT_ADDR_CMPL |=> bus_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
        else $error("read data changed without a read");
    a_high_toggle_cause: assert property ($changed(high_toggle_pin_o)
        |-> high_irq_request_o || $past(bus_wr_i && bus_addr_i == DMT_ADDR_CTRL))
        else $error("high pin moved without match or write");
    a_low_toggle_cause: assert property ($changed(low_toggle_pin_o)
        |-> low_irq_request_o || $past(bus_wr_i && bus_addr_i == DMT_ADDR_CTRL))
        else $error("low pin moved without match or write");
    a_low_idle_wide: assert property (!ctrl_q[6] && !$past(ctrl_q[6]) |-> !low_irq_request_o)
        else $error("low request in 16-bit mode");
    a_ext_quiet_hold: assert property (quiet_q == 3'h7 && !ctrl_q[6] && !ctrl_q[2]
        |-> !high_irq_request_o && $stable(high_toggle_pin_o))
        else $error("counting without an event edge");
endmodule : dmt_timer_asserts

/* dv/dmt_cpu_model.sv */
// byte-bus master standing in for the processor core
`timescale 1ns/1ps
module dmt_cpu_model (
    input wire logic core_clk_i,
    input wire logic [7:0] rdata_i,
    output logic [2:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    // event pin function is never switched from here
    initial begin
        addr_o = 3'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge core_clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge core_clk_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask : rd
    task automatic wr16(input logic [2:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(a + 3'h1, d[7:0]);
    endtask : wr16
    task automatic rd16(input logic [2:0] a, output logic [15:0] d);
        rd(a, d[15:8]);
        rd(a + 3'h1, d[7:0]);
    endtask : rd16
endmodule : dmt_cpu_model

/* dv/testbench.sv */
// self-checking bench of the dual mode compare timer
`timescale 1ns/1ps
module testbench;
    import dmt_pkg::*;
    logic clk, rst_n, wr, rd, pin, esel, hi_irq, lo_irq, hi_pin, lo_pin, r;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, v;
    logic [4:0] presc;
    logic [15:0] w;
    logic [31:0] seed;
    int error_cnt, num_checks, hi_n, lo_n, n;
    dmt_timer u_dmt_timer (
        .core_clk_i(clk), .resetn_i(rst_n), .bus_addr_i(addr), .bus_wr_i(wr),
        .bus_rd_i(rd), .bus_wdata_i(wdata), .presc_i(presc), .event_input_pin_i(pin),
        .event_edge_select_i(esel), .bus_rdata_o(rdata), .high_irq_request_o(hi_irq),
        .low_irq_request_o(lo_irq), .high_toggle_pin_o(hi_pin), .low_toggle_pin_o(lo_pin)
    );
    dmt_cpu_model u_cpu (.core_clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
        .rd_o(rd), .wdata_o(wdata));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    function automatic int edge_hit(input logic p, input logic c, input logic rise);
        return (p != c && c == rise) ? 1 : 0;
    endfunction : edge_hit
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) presc <= presc + 5'h1;
    always @(posedge clk) if (hi_irq === 1'b1) hi_n++;
    always @(posedge clk) if (lo_irq === 1'b1) lo_n++;
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("[ERR] watchdog expected done seen hang");
        test_done();
    end
    initial begin
        rst_n = 1'b0; pin = 1'b0; esel = 1'b0; presc = 5'h00;
        seed = 32'h38; error_cnt = 0; num_checks = 0; hi_n = 0; lo_n = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // address 6 is unmapped and must read zero
        for (int i = 0; i < 7; i++) begin
            u_cpu.rd(3'(i), v);
            chk("reset value", (i == 4 || i == 5) ? 8'hFF : 8'h00, v);
        end
        $display("test reset done");
        seed = xs(seed);
        r = seed[0];
        n = 0;
        @(posedge clk);
        esel <= r;
        repeat (40) begin
            @(posedge clk);
            seed = xs(seed);
            n += edge_hit(pin, seed[3], r);
            pin <= seed[3];
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        u_cpu.rd16(DMT_ADDR_CNTH, w);
        chk("event count", 16'(n), w);
        $display("test events done");
        u_cpu.wr16(DMT_ADDR_CNTH, 16'hAA55);
        u_cpu.rd16(DMT_ADDR_CNTH, w);
        chk("count word", 16'hAA55, w);
        u_cpu.wr16(DMT_ADDR_CMPH, 16'h1234);
        u_cpu.rd(DMT_ADDR_CMPL, v);
        chk("compare low", 8'h34, v);
        u_cpu.rd(DMT_ADDR_CMPH, v);
        chk("compare high", 8'h12, v);
        u_cpu.wr(DMT_ADDR_CTRL, 8'h88);
        #1 chk("pin levels", 2'b11, {hi_pin, lo_pin});
        u_cpu.wr(DMT_ADDR_CTRL, 8'h00);
        #1 chk("pin levels", 2'b00, {hi_pin, lo_pin});
        $display("test staging done");
        @(posedge clk);
        pin <= 1'b0;
        esel <= 1'b1;
        repeat (3) @(posedge clk);
        u_cpu.wr16(DMT_ADDR_CMPH, 16'hFFFF);
        u_cpu.wr16(DMT_ADDR_CNTH, 16'hFFFE);
        u_cpu.wr(DMT_ADDR_STAT, 8'h20);
        hi_n = 0;
        repeat (2) begin
            @(posedge clk);
            pin <= 1'b1;
            repeat (3) @(posedge clk);
            pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
        u_cpu.rd(DMT_ADDR_STAT, v);
        chk("flags", 8'hE0, v);
        chk("requests", 16'h2, 16'(hi_n));
        chk("toggle", 1'b1, hi_pin);
        u_cpu.wr(DMT_ADDR_STAT, 8'h20);
        u_cpu.rd(DMT_ADDR_STAT, v);
        chk("flag clear", 8'h20, v);
        u_cpu.wr(DMT_ADDR_STAT, 8'hFF);
        u_cpu.rd(DMT_ADDR_STAT, v);
        chk("flag set refused", 8'h33, v);
        $display("test wide match done");
        u_cpu.wr(DMT_ADDR_CTRL, 8'h77);
        u_cpu.wr(DMT_ADDR_STAT, 8'h11);
        u_cpu.wr(DMT_ADDR_CMPH, 8'h05);
        u_cpu.wr(DMT_ADDR_CMPL, 8'h09);
        hi_n = 0;
        repeat (100) @(posedge clk);
        u_cpu.rd(DMT_ADDR_STAT, v);
        chk("byte flags", 8'h55, v);
        u_cpu.rd(DMT_ADDR_CNTH, v);
        chk("high bound", 1'b1, v <= 8'h05);
        u_cpu.rd(DMT_ADDR_CNTL, v);
        chk("low bound", 1'b1, v <= 8'h09);
        chk("byte requests", 1'b1, hi_n > 4);
        $display("test byte mode done");
        // word mode at phi/2 with clear-on-match: the word never passes the compare value
        u_cpu.wr(DMT_ADDR_CTRL, 8'h07);
        u_cpu.wr16(DMT_ADDR_CMPH, 16'h0003);
        u_cpu.wr16(DMT_ADDR_CNTH, 16'h0000);
        repeat (50) @(posedge clk);
        u_cpu.rd16(DMT_ADDR_CNTH, w);
        chk("word bound", 1'b1, w <= 16'h0003);
        $display("test word clear done");
        // low byte alone, no clear: wrap sets its flag and request, then it matches 03
        u_cpu.wr(DMT_ADDR_CTRL, 8'h77);
        u_cpu.wr(DMT_ADDR_STAT, 8'h02);
        u_cpu.wr(DMT_ADDR_CNTL, 8'hF0);
        lo_n = 0;
        repeat (60) @(posedge clk);
        u_cpu.rd(DMT_ADDR_STAT, v);
        chk("low flags", 8'h0E, v & 8'h0E);
        chk("low requests", 1'b1, lo_n >= 2);
        $display("test byte overflow done");
        test_done();
    end
endmodule : testbench
bind dmt_timer dmt_timer_asserts u_dmt_timer_asserts (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i), .presc_i(presc_i),
    .event_input_pin_i(event_input_pin_i), .event_edge_select_i(event_edge_select_i),
    .bus_rdata_o(bus_rdata_o), .high_irq_request_o(high_irq_request_o),
    .low_irq_request_o(low_irq_request_o), .high_toggle_pin_o(high_toggle_pin_o),
    .low_toggle_pin_o(low_toggle_pin_o)
);
